// *** core/hsc_pkg.sv ***
// package: constants and types of the hot-swap control core
package hsc_pkg;
    // timing
    localparam int CLK_KHZ      = 200000;
    localparam int DEBOUNCE_MS  = 100;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;

    // fault log and present-state bit positions
    localparam int F_OV = 0;
    localparam int F_UV = 1;
    localparam int F_OC = 2;
    localparam int F_PB = 3;
    localparam int F_BD = 4;
    localparam int NF   = 5;
    localparam logic [NF-1:0] FLT_NONE = 5'h00;
    localparam logic [NF-1:0] FLT_ALL  = 5'h1f;
    localparam logic [NF-1:0] FLT_BD   = 5'h10;

    // serial command codes
    localparam logic [7:0] CMD_CTRL  = 8'h00;
    localparam logic [7:0] CMD_ALERT = 8'h01;
    localparam logic [7:0] CMD_STAT  = 8'h02;
    localparam logic [7:0] CMD_FAULT = 8'h03;
    localparam logic [7:0] CMD_ADC   = 8'h04;

    // control byte fields and reset values
    localparam int C_FETON = 0;
    localparam int C_GPM   = 1;
    localparam int C_GPOUT = 3;
    localparam logic [1:0] GPM_PGOOD = 2'h0;
    localparam logic [1:0] GPM_IN    = 2'h1;
    localparam logic [1:0] GPM_OUT   = 2'h2;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] ALERT_RST = 8'h00;

    // converter channel codes
    localparam logic [1:0] ADC_AUX  = 2'h0;
    localparam logic [1:0] ADC_VOUT = 2'h1;
    localparam logic [1:0] ADC_ISNS = 2'h2;

    // addressing
    localparam logic [6:0] ARA_ADDR  = 7'h0c;
    localparam logic [6:0] ADDR_BASE = 7'h40;
    localparam logic [6:0] TRI_W1    = 7'h03;
    localparam logic [6:0] TRI_W2    = 7'h09;
    localparam logic [1:0] SEL_LOW   = 2'h0;
    localparam logic [1:0] SEL_OPEN  = 2'h1;
    localparam logic [1:0] SEL_HIGH  = 2'h2;
    localparam logic [2:0] BIT_LAST  = 3'h7;

    typedef enum {HSC_INIT, HSC_RUN} hsc_ctl_t;
    typedef enum {L_IDLE, L_ADDR, L_AACK, L_CMD, L_CACK, L_DATA, L_DACK, L_RD, L_RACK} hsc_link_t;

    // three-level strap to a digit, code 3 read as high
    function automatic logic [1:0] hsc_lvl(input logic [1:0] s);
        return (s == SEL_LOW) ? SEL_LOW : ((s == SEL_OPEN) ? SEL_OPEN : SEL_HIGH);
    endfunction

    function automatic logic [6:0] hsc_addr(input logic [1:0] s2, input logic [1:0] s1, input logic [1:0] s0);
        return ADDR_BASE + TRI_W2 * {5'h00, hsc_lvl(s2)} + TRI_W1 * {5'h00, hsc_lvl(s1)} + {5'h00, hsc_lvl(s0)};
    endfunction
endpackage

// *** core/hsc_core.sv ***
`timescale 1ns/1ps
// hot-swap control core: pin conditioning, switch control, fault log and serial slave
//Contract
// - switch on only after 100ms board-present low
// - log every board-present transition
// - board insertion samples on input, clears faults
// - on rising turns on, falling turns off
// - on high at power-up sets bit after 100ms
// - on low at power-up waits host write
// - on falling edge clears logged faults
// - overvoltage logs fault, switch off
// - undervoltage logs fault, switch off
// - undervoltage reset level clears all faults
// - timer high trips breaker, switch off
// - breaker holds off until timer low
// - power bad shown and logged
// - gpio pulls low on power bad, configurable
// - alert pulls low for enabled faults only
// - answer the alert response address
// - three tri-level straps select 27 addresses
// - serial bits shifted on scl rising edges
// - separate data input and open-drain output
// - converter channel select among three inputs
// - hold init until both supply lockouts clear
// - present and latched faults readable
// - init clears faults, sets control defaults
// - insertion clears all but change bit, sets present
module hsc_core
    import hsc_pkg::*;
#(
    parameter int DEB_CYC = DEBOUNCE_CYC
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_b_in,
    input  wire logic       scl_in,
    input  wire logic       serial_data_in,
    input  wire logic       board_present_in,
    input  wire logic       on_control_in,
    input  wire logic       undervolt_cmp_in,
    input  wire logic       overvolt_cmp_in,
    input  wire logic       uv_reset_cmp_in,
    input  wire logic       timer_high_cmp_in,
    input  wire logic       timer_low_cmp_in,
    input  wire logic       power_good_cmp_in,
    input  wire logic       gpio_in,
    input  wire logic       supply_lockout_a_in,
    input  wire logic       supply_lockout_b_in,
    input  wire logic [1:0] addr_select_0_in,
    input  wire logic [1:0] addr_select_1_in,
    input  wire logic [1:0] addr_select_2_in,
    output logic            gate_on_out,
    output logic            serial_data_out,
    output logic            serial_data_oe_out,
    output logic            alert_out,
    output logic            alert_oe_out,
    output logic            gpio_out,
    output logic            gpio_oe_out,
    output logic [1:0]      adc_sel_out,
    output logic [NF-1:0]   fault_log_out,
    output logic            init_busy_out
);
    localparam int CW = $clog2(DEB_CYC + 1);
    localparam int NP = 17;
    localparam int NS = 48;

    // pin conditioning, two flops ahead of any logic
    logic [NP-1:0] pin_m_q;
    logic [NP-1:0] pin_s_q;
    always_ff @(posedge mclk_in) begin
        pin_m_q <= {board_present_in, on_control_in, undervolt_cmp_in, overvolt_cmp_in, uv_reset_cmp_in,
                    timer_high_cmp_in, timer_low_cmp_in, power_good_cmp_in, gpio_in, supply_lockout_a_in,
                    supply_lockout_b_in, addr_select_2_in, addr_select_1_in, addr_select_0_in};
        pin_s_q <= pin_m_q;
    end

    logic       bd_s, on_s, uv_s, ov_s, uvr_s, th_s, tl_s, pg_s, gp_s, la_s, lb_s;
    logic [1:0] a2_s, a1_s, a0_s;
    assign {bd_s, on_s, uv_s, ov_s, uvr_s, th_s, tl_s, pg_s, gp_s, la_s, lb_s, a2_s, a1_s, a0_s} = pin_s_q;

    // power-up sequencing: stay in init while any lockout holds
    hsc_ctl_t st_q;
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in || !la_s || !lb_s) begin
            st_q <= HSC_INIT;
        end else begin
            st_q <= HSC_RUN;
        end
    end

    logic run;
    logic init;
    assign run  = (st_q == HSC_RUN);
    assign init = !rst_b_in || !run;

    // edge detection on conditioned pins, loaded every cycle so init leaves no stale edge
    logic bd_p_q, on_p_q, th_p_q, pg_p_q;
    always_ff @(posedge mclk_in) begin
        bd_p_q <= bd_s;
        on_p_q <= on_s;
        th_p_q <= th_s;
        pg_p_q <= pg_s;
    end

    logic bd_rise, bd_fall, on_rise, on_fall, th_rise, pg_fall;
    assign bd_rise = run && bd_s && !bd_p_q;
    assign bd_fall = run && !bd_s && bd_p_q;
    assign on_rise = run && on_s && !on_p_q;
    assign on_fall = run && !on_s && on_p_q;
    assign th_rise = run && th_s && !th_p_q;
    assign pg_fall = run && !pg_s && pg_p_q;

    // host writes arrive as a toggle; command and data stay still until the next byte
    logic [2:0] wt_q;
    logic [2:0] at_q;
    logic       wtg_q, atg_q;
    logic [7:0] wcmd_q, wdat_q;
    always_ff @(posedge mclk_in) begin
        wt_q <= {wt_q[1:0], wtg_q};
        at_q <= {at_q[1:0], atg_q};
    end

    logic wr_ev, ara_ev;
    assign wr_ev  = run && (wt_q[2] != wt_q[1]);
    assign ara_ev = (at_q[2] != at_q[1]);

    // debounce: all entry conditions must hold for the full count
    logic          valid;
    logic          deb_done;
    logic [CW-1:0] deb_cnt_q;
    logic          qual_q;
    assign valid    = run && !bd_s && !uv_s && !ov_s;
    assign deb_done = valid && !qual_q && (deb_cnt_q == CW'(DEB_CYC - 1));
    always_ff @(posedge mclk_in) begin
        if (init || !valid) begin
            deb_cnt_q <= '0;
            qual_q    <= 1'b0;
        end else if (deb_done) begin
            qual_q    <= 1'b1;
        end else if (!qual_q) begin
            deb_cnt_q <= deb_cnt_q + CW'(1);
        end
    end

    // pending sample of the on input, armed at power-up and on insertion
    logic cap_q;
    always_ff @(posedge mclk_in) begin
        if (init) begin
            cap_q <= 1'b1;
        end else if (bd_fall) begin
            cap_q <= 1'b1;
        end else if (deb_done) begin
            cap_q <= 1'b0;
        end
    end

    // control, alert enable and converter channel; pin edges override a host write
    logic [7:0] ctrl_q;
    logic [7:0] aen_q;
    logic [1:0] adc_q;
    always_ff @(posedge mclk_in) begin
        if (init) begin
            ctrl_q <= CTRL_RST;
            aen_q  <= ALERT_RST;
            adc_q  <= ADC_AUX;
        end else begin
            if (wr_ev && wcmd_q == CMD_CTRL) begin
                ctrl_q <= wdat_q;
            end
            if (wr_ev && wcmd_q == CMD_ALERT) begin
                aen_q <= wdat_q;
            end
            // code 3 names no channel and is ignored
            if (wr_ev && wcmd_q == CMD_ADC && wdat_q[1:0] != 2'h3) begin
                adc_q <= wdat_q[1:0];
            end
            if (deb_done && cap_q) begin
                ctrl_q[C_FETON] <= on_s;
            end
            if (on_rise) begin
                ctrl_q[C_FETON] <= 1'b1;
            end
            if (on_fall) begin
                ctrl_q[C_FETON] <= 1'b0;
            end
        end
    end

    // fault events and clears; an event in the clearing cycle survives
    logic [NF-1:0] fset, fclr, fault_q;
    always_comb begin
        fset       = FLT_NONE;
        fset[F_OV] = run && ov_s;
        fset[F_UV] = run && uv_s;
        fset[F_OC] = th_rise;
        fset[F_PB] = pg_fall;
        fset[F_BD] = bd_rise || bd_fall;
        fclr       = FLT_NONE;
        if (bd_fall) begin
            fclr = FLT_ALL & ~FLT_BD;
        end
        if (on_fall) begin
            fclr = FLT_ALL;
        end
        if (run && uvr_s) begin
            fclr = FLT_ALL;
        end
        if (wr_ev && wcmd_q == CMD_FAULT) begin
            fclr = fclr | ~wdat_q[NF-1:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (init) begin
            fault_q <= FLT_NONE;
        end else begin
            fault_q <= (fault_q & ~fclr) | fset;
        end
    end

    // circuit breaker latch: trips on timer high, released at timer low
    logic cb_lock_q;
    always_ff @(posedge mclk_in) begin
        if (init) begin
            cb_lock_q <= 1'b0;
        end else if (run && th_s) begin
            cb_lock_q <= 1'b1;
        end else if (tl_s) begin
            cb_lock_q <= 1'b0;
        end
    end

    // switch command; board and voltage off conditions act in the next cycle, timer high and on falling one cycle later
    logic gate_d;
    assign gate_d = run && qual_q && ctrl_q[C_FETON] && !bd_s && !uv_s && !ov_s && !cb_lock_q;
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            gate_on_out <= 1'b0;
        end else begin
            gate_on_out <= gate_d;
        end
    end

    // alert: new enabled fault arms it, alert response releases it, arming wins
    logic aset;
    assign aset = |(fset & ~fault_q & aen_q[NF-1:0]);
    always_ff @(posedge mclk_in) begin
        if (init) begin
            alert_oe_out <= 1'b0;
        end else begin
            alert_oe_out <= aset || (alert_oe_out && !ara_ev);
        end
    end

    // gpio function select; the open-drain low level is fixed
    always_ff @(posedge mclk_in) begin
        if (init) begin
            gpio_oe_out <= 1'b0;
        end else begin
            unique case (ctrl_q[C_GPM +: 2])
                GPM_PGOOD: gpio_oe_out <= !pg_s;
                GPM_IN:    gpio_oe_out <= 1'b0;
                GPM_OUT:   gpio_oe_out <= !ctrl_q[C_GPOUT];
                default:   gpio_oe_out <= 1'b0;
            endcase
        end
    end

    // open-drain levels, user-visible status
    always_ff @(posedge mclk_in) begin
        serial_data_out <= 1'b0;
        alert_out       <= 1'b0;
        gpio_out        <= 1'b0;
        adc_sel_out     <= adc_q;
        fault_log_out   <= fault_q;
        init_busy_out   <= init;
    end

    // read snapshot for the link; bytes may tear across a change, a re-read settles it
    logic [6:0]    own_q;
    logic [NF-1:0] pres;
    logic [NS-1:0] snap_q;
    logic          lnk_clr_q;
    assign pres = {!bd_s, !pg_s, cb_lock_q, uv_s, ov_s};
    always_ff @(posedge mclk_in) begin
        own_q     <= hsc_addr(a2_s, a1_s, a0_s);
        snap_q    <= {own_q, alert_oe_out, ctrl_q, aen_q, 2'h0, gp_s, pres, 3'h0, fault_q, 6'h00, adc_q};
        lnk_clr_q <= !rst_b_in;
    end

    // link side: reset and snapshot brought onto scl
    logic          lr_m_q, lr_q;
    logic [NS-1:0] lsn_m_q, lsn_q;
    logic [7:0]    sh_q;
    always_ff @(posedge scl_in) begin
        lr_m_q  <= rst_b_in;
        lr_q    <= lr_m_q;
        lsn_m_q <= snap_q;
        lsn_q   <= lsn_m_q;
        sh_q    <= {sh_q[6:0], serial_data_in};
    end

    logic [6:0] lown;
    logic       lpend;
    logic [7:0] lctrl, laen, lstat, lflt, ladc;
    assign {lown, lpend, lctrl, laen, lstat, lflt, ladc} = lsn_q;

    // start marker: sda falling while scl high; settles well before the next scl fall
    logic stg_q;
    always_ff @(negedge serial_data_in or posedge lnk_clr_q) begin
        if (lnk_clr_q) begin
            stg_q <= 1'b0;
        end else if (scl_in) begin
            stg_q <= ~stg_q;
        end
    end

    hsc_link_t  lst_q;
    logic [2:0] bc_q;
    logic [7:0] cmd_q, tx_q, txv;
    logic       seen_q, rw_q, ara_q, bdone;
    assign bdone = (bc_q == BIT_LAST);

    // byte for a read: own address for an alert response, else the selected register
    always_comb begin
        unique case (cmd_q)
            CMD_CTRL:  txv = lctrl;
            CMD_ALERT: txv = laen;
            CMD_STAT:  txv = lstat;
            CMD_FAULT: txv = lflt;
            CMD_ADC:   txv = ladc;
            default:   txv = 8'h00;
        endcase
        if (ara_q) begin
            txv = {lown, 1'b0};
        end
    end

    // slave sequencer on scl falling: drives ack and read bits while scl is low
    always_ff @(negedge scl_in) begin
        if (!lr_q) begin
            lst_q  <= L_IDLE;
            bc_q   <= 3'h0;
            serial_data_oe_out <= 1'b0;
            seen_q <= 1'b0;
            rw_q   <= 1'b0;
            ara_q  <= 1'b0;
            cmd_q  <= CMD_CTRL;
            tx_q   <= 8'h00;
            wcmd_q <= CMD_CTRL;
            wdat_q <= 8'h00;
            wtg_q  <= 1'b0;
            atg_q  <= 1'b0;
        end else if (seen_q != stg_q) begin
            seen_q <= stg_q;
            lst_q  <= L_ADDR;
            bc_q   <= 3'h0;
            serial_data_oe_out <= 1'b0;
        end else begin
            unique case (lst_q)
                L_IDLE: serial_data_oe_out <= 1'b0;
                L_ADDR: begin
                    bc_q <= bc_q + 3'h1;
                    if (bdone) begin
                        if (sh_q[7:1] == lown || (sh_q == {ARA_ADDR, 1'b1} && lpend)) begin
                            serial_data_oe_out <= 1'b1;
                            rw_q  <= sh_q[0];
                            ara_q <= (sh_q[7:1] == ARA_ADDR);
                            lst_q <= L_AACK;
                        end else begin
                            lst_q <= L_IDLE;
                        end
                    end
                end
                L_AACK: begin
                    bc_q <= 3'h0;
                    if (rw_q) begin
                        serial_data_oe_out <= ~txv[7];
                        tx_q  <= {txv[6:0], 1'b0};
                        atg_q <= atg_q ^ ara_q;
                        lst_q <= L_RD;
                    end else begin
                        serial_data_oe_out <= 1'b0;
                        lst_q <= L_CMD;
                    end
                end
                L_CMD: begin
                    bc_q <= bc_q + 3'h1;
                    if (bdone) begin
                        cmd_q <= sh_q;
                        serial_data_oe_out <= 1'b1;
                        lst_q <= L_CACK;
                    end
                end
                L_DATA: begin
                    bc_q <= bc_q + 3'h1;
                    if (bdone) begin
                        wcmd_q <= cmd_q;
                        wdat_q <= sh_q;
                        wtg_q  <= ~wtg_q;
                        serial_data_oe_out <= 1'b1;
                        lst_q  <= L_DACK;
                    end
                end
                L_CACK, L_DACK: begin
                    bc_q  <= 3'h0;
                    serial_data_oe_out <= 1'b0;
                    lst_q <= L_DATA;
                end
                L_RD: begin
                    bc_q <= bc_q + 3'h1;
                    if (bdone) begin
                        serial_data_oe_out <= 1'b0;
                        lst_q <= L_RACK;
                    end else begin
                        serial_data_oe_out <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
                L_RACK: begin
                    bc_q <= 3'h0;
                    if (!sh_q[0]) begin
                        serial_data_oe_out <= ~txv[7];
                        tx_q  <= {txv[6:0], 1'b0};
                        lst_q <= L_RD;
                    end else begin
                        serial_data_oe_out <= 1'b0;
                        lst_q <= L_IDLE;
                    end
                end
            endcase
        end
    end

    // checks on the control clock
    default clocking cb_m @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    chk_bd_gate_off: assert property (bd_s |=> !gate_on_out)
        else $error("switch on while board absent");
    chk_bd_change_log: assert property ((bd_rise || bd_fall) |=> fault_q[F_BD])
        else $error("board change not logged");
    chk_insert_capture: assert property (bd_fall |=> cap_q)
        else $error("insertion did not arm on sample");
    chk_on_edge_fet: assert property (on_rise |=> ctrl_q[C_FETON] ##0 !on_fall)
        else $error("on rising edge did not set switch bit");
    chk_on_fall_clear: assert property (on_fall && fset == FLT_NONE |=> fault_q == FLT_NONE && !ctrl_q[C_FETON])
        else $error("on falling edge did not clear");
    chk_ov_trip: assert property (run && ov_s |=> fault_q[F_OV] && !gate_on_out)
        else $error("overvoltage not handled");
    chk_uv_trip: assert property (run && uv_s |=> fault_q[F_UV] && !gate_on_out)
        else $error("undervoltage not handled");
    chk_uvr_clear: assert property (run && uvr_s && fset == FLT_NONE |=> fault_q == FLT_NONE)
        else $error("reset level did not clear faults");
    chk_insert_clear: assert property (bd_fall && !th_rise && !pg_fall |=> !fault_q[F_OC] && !fault_q[F_PB])
        else $error("insertion left faults");
    chk_cb_hold: assert property (cb_lock_q |=> !gate_on_out)
        else $error("switch on during breaker off time");
    chk_alert_cause: assert property ($rose(alert_oe_out) |-> $past(aset))
        else $error("alert without enabled fault");
    chk_gpio_pbad: assert property (run && ctrl_q[C_GPM +: 2] == GPM_PGOOD && !pg_s |=> gpio_oe_out)
        else $error("gpio not low on power bad");
    chk_init_clean: assert property (st_q == HSC_INIT |=> !gate_on_out && fault_q == FLT_NONE && ctrl_q == CTRL_RST)
        else $error("init left state set");
    chk_deb_full: assert property ($rose(qual_q) |-> $past(deb_cnt_q) == CW'(DEB_CYC - 1) && $past(valid))
        else $error("debounce finished early");

    cov_gate_on: cover property ($rose(gate_on_out));
    cov_alert: cover property ($rose(alert_oe_out));
    cov_ara: cover property (alert_oe_out && ara_ev);
    cov_host_on: cover property (wr_ev && wcmd_q == CMD_CTRL && wdat_q[C_FETON]);
endmodule // hsc_core

// *** bench/hsc_host_model.sv ***
`timescale 1ns/1ps
// serial bus host model: drives the clock and pulls data low, never drives high
module hsc_host_model
    import hsc_pkg::*;
(
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // clock idles high and data released outside frames
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // free clocks with data high: only used around reset, no start is formed
    task automatic idle(input int n);
        repeat (n) begin
            #15 scl_out = 1'b0;
            #15 scl_out = 1'b1;
        end
    endtask
    // start or repeated start: data falls while clock is high
    task automatic start();
        sda_low_out = 1'b0;
        #8 scl_out = 1'b1;
        #15 sda_low_out = 1'b1;
        #15 scl_out = 1'b0;
    endtask
    // data set while clock low, sampled on the rising edge
    task automatic bit_io(input logic b, output logic s);
        #7 sda_low_out = !b;
        #8 scl_out = 1'b1;
        s = sda_in;
        #15 scl_out = 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s); // msb first
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // last byte is refused so the core lets go of the line
    task automatic rd_byte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(1'b1, s);
    endtask
    task automatic stop();
        #7 sda_low_out = 1'b1;
        #8 scl_out = 1'b1;
        #15 sda_low_out = 1'b0;
    endtask
    // register write, also the host turn-on command
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        start();
        wr_byte({a, 1'b0}, k0);
        wr_byte(c, k1);
        wr_byte(d, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    // register read through a repeated start
    task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        start();
        wr_byte({a, 1'b0}, k0);
        wr_byte(c, k1);
        start();
        wr_byte({a, 1'b1}, k2);
        rd_byte(d);
        stop();
        ok = k0 & k1 & k2;
    endtask
    // alert response read at the shared address
    task automatic ara(output logic [7:0] d, output logic ok);
        start();
        wr_byte({ARA_ADDR, 1'b1}, ok);
        rd_byte(d);
        stop();
    endtask
endmodule // hsc_host_model

// *** bench/hot_swap_control_logic_tb_top.sv ***
`timescale 1ns/1ps
// testbench: pin scenarios and serial host traffic against the control core
module hot_swap_control_logic_tb_top
    import hsc_pkg::*;
;
    logic mclk_in = 0, rst_b_in = 0, brd = 0, on = 0, uv = 0, ov = 0, uvr = 0;
    logic th = 0, tl = 1, pg = 1, ok;
    logic la = 1'b1, lb = 1'b1, gpi = 1'b1;
    logic [1:0] a0 = 2'h0, a1 = 2'h0, a2 = 2'h0;
    logic [7:0] d;
    logic [4:0] flog;
    logic gate, oe, aoe, goe, busy;
    logic [1:0] sel;
    wire scl, sda_low;
    int error_cnt = 0, n_tests = 0;
    // shared data line: pull-up, low if either side pulls
    wire sda = !(sda_low | oe);
    always #2.5 mclk_in = !mclk_in;
    hsc_host_model i_host (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
    hsc_core #(.DEB_CYC(50)) i_dut (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .scl_in(scl), .serial_data_in(sda),
        .board_present_in(brd), .on_control_in(on), .undervolt_cmp_in(uv), .overvolt_cmp_in(ov),
        .uv_reset_cmp_in(uvr), .timer_high_cmp_in(th), .timer_low_cmp_in(tl), .power_good_cmp_in(pg),
        .gpio_in(gpi), .supply_lockout_a_in(la), .supply_lockout_b_in(lb),
        .addr_select_0_in(a0), .addr_select_1_in(a1), .addr_select_2_in(a2),
        .gate_on_out(gate), .serial_data_out(), .serial_data_oe_out(oe), .alert_out(),
        .alert_oe_out(aoe), .gpio_out(), .gpio_oe_out(goe), .adc_sel_out(sel),
        .fault_log_out(flog), .init_busy_out(busy));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // on held low at power-up: switch waits for the host
    task automatic t_pwr();
        cyc(80);
        chk(busy, 0);
        chk(gate, 0);
        i_host.wr(ADDR_BASE, CMD_CTRL, 8'h01, ok);
        cyc(10);
        chk(gate, 1);
        $display("done power-up");
    endtask
    task automatic t_on();
        on = 1;
        cyc(5);
        on = 0;
        cyc(5);
        chk(gate, 0);
        on = 1;
        cyc(5);
        chk(gate, 1);
        $display("done on edges");
    endtask
    // overvoltage trip, auto return, then on falling clears the log
    task automatic t_ov();
        ov = 1;
        cyc(5);
        chk(gate, 0);
        chk(flog[F_OV], 1);
        ov = 0;
        cyc(70);
        chk(gate, 1);
        on = 0;
        cyc(5);
        chk(flog, FLT_NONE);
        on = 1;
        cyc(5);
        $display("done overvoltage");
    endtask
    task automatic t_uv();
        uv = 1;
        cyc(5);
        chk(gate, 0);
        chk(flog[F_UV], 1);
        uv = 0;
        uvr = 1;
        cyc(5);
        chk(flog, FLT_NONE);
        uvr = 0;
        cyc(70);
        chk(gate, 1);
        $display("done undervoltage");
    endtask
    // breaker holds off long after the trip until timer low returns
    task automatic t_cb();
        th = 1;
        tl = 0;
        cyc(5);
        chk(gate, 0);
        chk(flog[F_OC], 1);
        th = 0;
        cyc(70);
        chk(gate, 0);
        tl = 1;
        cyc(10);
        chk(gate, 1);
        $display("done breaker");
    endtask
    task automatic t_pg();
        pg = 0;
        cyc(5);
        chk(flog[F_PB], 1);
        chk(goe, 1);
        pg = 1;
        cyc(5);
        chk(goe, 0);
        i_host.wr(ADDR_BASE, CMD_CTRL, 8'h05, ok);
        cyc(10);
        chk(goe, 1);
        i_host.wr(ADDR_BASE, CMD_CTRL, 8'h01, ok);
        $display("done power good");
    endtask
    // only the enabled fault pulls alert; response names us and releases it
    task automatic t_alert();
        i_host.wr(ADDR_BASE, CMD_FAULT, 8'h00, ok);
        i_host.wr(ADDR_BASE, CMD_ALERT, 8'h01, ok);
        cyc(1);
        pg = 0;
        cyc(5);
        chk(aoe, 0);
        pg = 1;
        ov = 1;
        cyc(5);
        ov = 0;
        chk(aoe, 1);
        i_host.rd(ADDR_BASE, CMD_FAULT, d, ok);
        chk(d, 8'h09);
        i_host.rd(ADDR_BASE, CMD_STAT, d, ok);
        chk(d, 8'h30);
        i_host.ara(d, ok);
        chk(d, {ADDR_BASE, 1'b0});
        cyc(10);
        chk(aoe, 0);
        $display("done alert");
    endtask
    // removal, then insertion with full debounce before turn-on
    task automatic t_board();
        brd = 1;
        cyc(5);
        chk(gate, 0);
        chk(flog[F_BD], 1);
        brd = 0;
        cyc(30);
        chk(gate, 0);
        chk(flog, FLT_BD);
        cyc(45);
        chk(gate, 1);
        $display("done board");
    endtask
    task automatic t_lock();
        la = 1'b0;
        cyc(6);
        chk(busy, 1);
        chk(gate, 0);
        chk(flog, FLT_NONE);
        la = 1'b1;
        lb = 1'b0;
        cyc(6);
        chk(busy, 1);
        lb = 1'b1;
        cyc(70);
        chk(gate, 1);
        $display("done lockout");
    endtask
    task automatic t_adc();
        for (int i = 2; i >= 0; i--) begin
            i_host.wr(ADDR_BASE, CMD_ADC, 8'(i), ok);
            cyc(10);
            chk(sel, 8'(i));
        end
        i_host.wr(ADDR_BASE + 7'h01, CMD_ADC, 8'h01, ok);
        chk(ok, 0);
        cyc(1);
        a0 = 2'h1;
        cyc(5);
        i_host.wr(ADDR_BASE + 7'h01, CMD_ADC, 8'h01, ok);
        cyc(10);
        chk(ok, 1);
        chk(sel, 8'h01);
        $display("done converter select");
    endtask
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
    initial begin
        #3;
        i_host.idle(2);
        chk(busy, 1);
        chk(flog, FLT_NONE);
        @(negedge mclk_in);
        rst_b_in = 1;
        i_host.idle(3);
        t_pwr();
        t_on();
        t_ov();
        t_uv();
        t_cb();
        t_pg();
        t_alert();
        t_board();
        t_lock();
        t_adc();
        summarize();
    end
endmodule // hot_swap_control_logic_tb_top
